// ==== dv/wdgp_pin_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// Board side of the general purpose pins
module wdgp_pin_model
    import wdgp_pkg::*;
(
    // Drive from the block
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    // Level set by the board where no one drives
    input wire logic [5:0] board_level,
    // Resolved wire level fed back to the block
    output logic [5:0] pin_level
);
    // A driven pin shows the block's value; an undriven one shows the board
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & board_level);
endmodule : wdgp_pin_model

// ==== dv/wdgp_top_tb.sv ====
`timescale 1ns/10ps
`include "wdgp_defs.svh"
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin num_errors++; $display("mismatch at %0t: got %0h expected %0h", $time, g, x); end end

module wdgp_top_tb;
    localparam int CPS = 10;
    logic hclk, hresetn, hsel, hwrite, kbd, mouse, io_strobe, ir_tx, hreadyout, hresp, ir_rx;
    logic comb_irq, wd_irq, wd_to, p10_irq, p11_irq, inv;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [11:0] io_address;
    logic [3:0] wd_chan;
    logic [5:0] pin_out, pin_oe, pin_level, board, stored;
    logic [7:0] cfg, d;
    int num_errors, n_tests, i, e, c, n, s;

    // ======================================================
    // Design and board model
    wdgp_top #(.CYC_PER_SEC(CPS)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .keyboard_irq(kbd), .mouse_irq(mouse),
        .io_strobe(io_strobe), .io_address(io_address), .infrared_transmit(ir_tx), .infrared_receive(ir_rx),
        .general_purpose_pin_in(pin_level), .general_purpose_pin_out(pin_out),
        .general_purpose_pin_oe(pin_oe), .combined_pin_interrupt(comb_irq), .watchdog_irq(wd_irq),
        .watchdog_irq_channel(wd_chan), .gpio_pin_10_irq(p10_irq), .gpio_pin_11_irq(p11_irq),
        .watchdog_timeout(wd_to));
    wdgp_pin_model i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .board_level(board), .pin_level(pin_level));

    // ======================================================
    // Closing report and bus tasks
    task stop_test;
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    // Bounded wait for the slave's ready at a rising edge
    task wait_rdy;
        int k;
        @(posedge hclk);
        for (k = 0; k < 50 && hreadyout !== 1'b1; k++)
            @(posedge hclk);
        if (k == 50)
        begin
            num_errors++;
            stop_test();
        end
    endtask : wait_rdy

    // One single word transfer; read data taken at the data phase edge
    task xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] v);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr_en;
        haddr <= {24'h000000, a};
        hsize <= 3'b010;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= v;
        wait_rdy();
        rd = hrdata;
    endtask : xfer

    task wr(input logic [7:0] a, input logic [7:0] v);
        xfer(1'b1, a, {24'h000000, v});
    endtask : wr

    task rdr(input logic [7:0] a);
        xfer(1'b0, a, 32'h00000000);
    endtask : rdr

    task tick(input int k);
        repeat (k) @(posedge hclk);
    endtask : tick

    // Restart event: 0 game port, 1 keyboard, 2 mouse, 3 strobe at a neighbour address
    task fire(input int ev);
        io_strobe <= (ev == 0 || ev == 3);
        io_address <= (ev == 3) ? 12'h200 : `WDGP_GAME_ADDR;
        kbd <= (ev == 1);
        mouse <= (ev == 2);
        @(posedge hclk);
        io_strobe <= 1'b0;
        kbd <= 1'b0;
        mouse <= 1'b0;
        @(posedge hclk);
    endtask : fire

    // Cycles until the timeout output rises, bounded
    task wait_to(output int cnt);
        for (cnt = 0; cnt < 3000 && wd_to !== 1'b1; cnt++)
            @(posedge hclk);
        if (cnt == 3000)
        begin
            num_errors++;
            stop_test();
        end
    endtask : wait_to

    // Window for a count of units: the free prescaler may shorten the first unit
    function automatic logic in_window(input int cnt, input int units, input int per);
        return cnt >= (units - 1) * per && cnt <= units * per + 8;
    endfunction : in_window

    // ======================================================
    // Clock
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ======================================================
    // Main sequence
    initial
    begin
        {hresetn, hsel, hwrite, kbd, mouse, io_strobe, ir_tx} = '0;
        {haddr, hwdata, htrans, hsize, io_address, board, stored} = '0;
        num_errors = 0;
        n_tests = 0;
        void'($urandom(61456));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdr(`WDGP_OFF_RELOAD); `CHK(rd, 32'h00000000)
        rdr(`WDGP_OFF_PIN_CFG + 8'h08); `CHK(rd[7:0], `WDGP_PIN_CFG_RST)
        rdr(8'hFC); `CHK(rd, 32'h00000000)
        `CHK(hresp, 1'b0)
        wr(`WDGP_OFF_CONTROL, 8'h01); rdr(`WDGP_OFF_CONTROL); `CHK(rd[0], 1'b1)
        wr(`WDGP_OFF_CONTROL, 8'h00); rdr(`WDGP_OFF_CONTROL); `CHK(rd[0], 1'b0)
        tick(100); `CHK(wd_to, 1'b0)
        // Second units: smallest, largest and a random count
        for (i = 0; i < 3; i++)
        begin
            n = (i == 0) ? 1 : (i == 1) ? 255 : 2 + $urandom % 6;
            wr(`WDGP_OFF_RELOAD, 8'(n));
            wait_to(c); `CHK(in_window(c, n, CPS), 1'b1)
            rdr(`WDGP_OFF_CONTROL); `CHK(rd[0], 1'b1)
            wr(`WDGP_OFF_CONTROL, 8'h00); tick(3); `CHK(wd_to, 1'b0)
        end
        // Minute units
        wr(`WDGP_OFF_DEC_EN, 8'h80); wr(`WDGP_OFF_RELOAD, 8'h02);
        tick(500); `CHK(wd_to, 1'b0)
        wait_to(c); `CHK(c <= 20 * CPS * 6 - 500 + 8, 1'b1)
        wr(`WDGP_OFF_DEC_EN, 8'h00); wr(`WDGP_OFF_RELOAD, 8'h05);
        // Each restart event alone, with its interrupt channel
        for (e = 0; e < 3; e++)
        begin
            wr(`WDGP_OFF_CONFIG, {4'(e + 3), 4'(1 << e)}); wr(`WDGP_OFF_CONTROL, 8'h04);
            tick(3); `CHK(wd_to, 1'b1)
            `CHK(wd_irq, 1'b1)
            `CHK(wd_chan, 4'(e + 3))
            rdr(`WDGP_OFF_CONTROL); `CHK(rd[2:0], 3'b001)
            fire((e + 1) % 3); fire(3); tick(3); `CHK(wd_to, 1'b1)
            fire(e); tick(3); `CHK(wd_to, 1'b0)
            `CHK(wd_irq, 1'b0)
            tick(30); `CHK(wd_to, 1'b0)
            wait_to(c); `CHK(c <= 25, 1'b1)
        end
        wr(`WDGP_OFF_CONFIG, 8'h07); tick(3); `CHK(wd_irq, 1'b0)
        // Timeout flag on pins 12 and 46, both polarities
        for (i = 0; i < 2; i++)
        begin
            inv = i[0];
            wr(`WDGP_OFF_CONTROL, 8'h01);
            wr(`WDGP_OFF_PIN_CFG + 8'h08, {6'h02, inv, 1'b0}); wr(`WDGP_OFF_PIN_CFG + 8'h10, {6'h02, inv, 1'b0});
            tick(3); `CHK(pin_out[2], ~inv)
            `CHK(pin_out[4], ~inv)
            `CHK(pin_oe[2], 1'b1)
            wr(`WDGP_OFF_CONTROL, 8'h00); tick(3); `CHK(pin_out[2], inv)
        end
        // Pin 13 as LED driver, then pins 12 and 13 as infrared
        wr(`WDGP_OFF_PIN_CFG + 8'h0C, 8'h08); tick(3); `CHK(pin_out[3], 1'b1)
        wr(`WDGP_OFF_IR_OPT, 8'h40); wr(`WDGP_OFF_PIN_CFG + 8'h08, 8'h09);
        for (i = 0; i < 2; i++)
        begin
            ir_tx <= i[0];
            board[2] <= i[0];
            tick(5); `CHK(pin_out[3], i[0])
            `CHK(ir_rx, i[0])
        end
        wr(`WDGP_OFF_IR_OPT, 8'h00);
        for (s = 2; s < 5; s++)
            wr(`WDGP_OFF_PIN_CFG + 8'(4 * s), 8'h01);
        // Pins 10 and 11 on their own interrupt channels
        for (s = 0; s < 2; s++)
        begin
            wr(`WDGP_OFF_PIN_CFG + 8'(4 * s), 8'h59);
            rdr(`WDGP_OFF_PIN_CFG + 8'(4 * s)); `CHK(rd[7:4], 4'h5)
            board[s] <= 1'b1;
            tick(5); `CHK(s ? p11_irq : p10_irq, 1'b1)
            board[s] <= 1'b0;
            tick(5); `CHK(s ? p11_irq : p10_irq, 1'b0)
            wr(`WDGP_OFF_PIN_CFG + 8'(4 * s), 8'h01);
        end
        // Plain pins with random direction, polarity and interrupt enable
        for (i = 0; i < 16; i++)
        begin
            s = $urandom % 6;
            cfg = 8'($urandom % 8);
            d = 8'($urandom);
            board <= 6'($urandom);
            inv = cfg[1];
            wr(`WDGP_OFF_PIN_CFG + 8'(4 * s), cfg); wr(`WDGP_OFF_PIN_DATA, d); tick(4);
            rdr(`WDGP_OFF_PIN_DATA);
            if (cfg[0])
            begin
                `CHK(rd[s], board[s] ^ inv)
                `CHK(pin_oe[s], 1'b0)
                `CHK(comb_irq, cfg[2] & (board[s] ^ inv))
                wr(`WDGP_OFF_PIN_CFG + 8'(4 * s), 8'h00); tick(4); `CHK(pin_out[s], stored[s])
            end
            else
            begin
                stored[s] = d[s];
                `CHK(rd[s], d[s])
                `CHK(pin_out[s], d[s] ^ inv)
                `CHK(pin_oe[s], 1'b1)
            end
            wr(`WDGP_OFF_PIN_CFG + 8'(4 * s), 8'h01);
        end
        stop_test();
    end
endmodule : wdgp_top_tb

// ==== logic/wdgp_defs.svh ====
`ifndef WDGP_DEFS_SVH
`define WDGP_DEFS_SVH

// ==========================================================
// Register byte offsets
`define WDGP_OFF_RELOAD 8'h00
`define WDGP_OFF_CONFIG 8'h04
`define WDGP_OFF_CONTROL 8'h08
`define WDGP_OFF_DEC_EN 8'h0C
`define WDGP_OFF_IR_OPT 8'h10
`define WDGP_OFF_PIN_DATA 8'h14
`define WDGP_OFF_PIN_CFG 8'h20

// ==========================================================
// Field positions
`define WDGP_CTRL_STATUS 0
`define WDGP_CTRL_FORCE 2
`define WDGP_CFG_JOY_EN 0
`define WDGP_CFG_KBD_EN 1
`define WDGP_CFG_MOUSE_EN 2
`define WDGP_DEC_UNIT_MIN 7
`define WDGP_IR_SELECT 6

// ==========================================================
// Pin slots: 10, 11, 12, 13, 46, 61
`define WDGP_NPINS 6
`define WDGP_PIN_10 0
`define WDGP_PIN_11 1
`define WDGP_PIN_12 2
`define WDGP_PIN_13 3
`define WDGP_PIN_46 4
`define WDGP_PIN_61 5

// ==========================================================
// Reset values and constants
`define WDGP_RELOAD_RST 8'h00
`define WDGP_PIN_CFG_RST 8'h01
`define WDGP_GAME_ADDR 12'h201

// ==========================================================
// Timing
`define WDGP_CLK_NS 10
`define WDGP_SEC_NS 1000000000
`define WDGP_CYC_PER_SEC (`WDGP_SEC_NS / `WDGP_CLK_NS)
`define WDGP_SEC_PER_MIN 60

`endif

// ==== logic/wdgp_pkg.sv ====
package wdgp_pkg;

    // ======================================================
    // Pin configuration register layout
    typedef struct packed {
        logic [3:0] channel;
        logic alt;
        logic int_en;
        logic invert;
        logic is_input;
    } wdgp_pin_cfg_type;

    // ======================================================
    // Watchdog control register layout
    typedef struct packed {
        logic [4:0] spare;
        logic force_out;
        logic led_toggle;
        logic status;
    } wdgp_ctrl_type;

    // ======================================================
    // Latched AHB address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] offset;
    } wdgp_ahb_req_type;

endpackage : wdgp_pkg

// ==== logic/wdgp_top.sv ====
`timescale 1ns/10ps
`include "wdgp_defs.svh"
module wdgp_top
    import wdgp_pkg::*;
#(
    parameter int unsigned CYC_PER_SEC = `WDGP_CYC_PER_SEC
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Restart events, same clock
    input wire logic keyboard_irq,
    input wire logic mouse_irq,
    input wire logic io_strobe,
    input wire logic [11:0] io_address,
    // Infrared port
    input wire logic infrared_transmit,
    output logic infrared_receive,
    // General purpose pins
    input wire logic [`WDGP_NPINS-1:0] general_purpose_pin_in,
    output logic [`WDGP_NPINS-1:0] general_purpose_pin_out,
    output logic [`WDGP_NPINS-1:0] general_purpose_pin_oe,
    // Interrupt lines
    output logic combined_pin_interrupt,
    output logic watchdog_irq,
    output logic [3:0] watchdog_irq_channel,
    output logic gpio_pin_10_irq,
    output logic gpio_pin_11_irq,
    output logic watchdog_timeout
);

    // ======================================================
    // Registers
    logic [7:0] watchdog_reload_value;
    logic [7:0] watchdog_config;
    wdgp_ctrl_type watchdog_control;
    logic [7:0] address_decode_enable;
    logic [7:0] ir_options;
    logic [`WDGP_NPINS-1:0] pin_data;
    wdgp_pin_cfg_type pin_config [`WDGP_NPINS];
    wdgp_ahb_req_type req;
    logic [7:0] count;
    logic [31:0] sec_cnt;
    logic [5:0] min_cnt;
    logic [`WDGP_NPINS-1:0] pin_meta;
    logic [`WDGP_NPINS-1:0] pin_sync;
    logic kbd_q, mouse_q, game_q;

    // ======================================================
    // Bus decode
    // The whole request is an argument, so callers in continuous assignments see valid and write change too
    function automatic logic hit(input wdgp_ahb_req_type r, input logic [7:0] want);
        hit = r.valid && r.write && r.offset == want;
    endfunction : hit

    wire logic take = hsel && htrans[1] && hready;
    wire logic [7:0] aoff = haddr[7:0];
    wire logic [7:0] wbyte = hwdata[7:0];
    wire logic wr_reload = hit(req, `WDGP_OFF_RELOAD);
    wire logic wr_config = hit(req, `WDGP_OFF_CONFIG);
    wire logic wr_ctrl = hit(req, `WDGP_OFF_CONTROL);
    wire logic wr_dec = hit(req, `WDGP_OFF_DEC_EN);
    wire logic wr_ir = hit(req, `WDGP_OFF_IR_OPT);
    wire logic wr_data = hit(req, `WDGP_OFF_PIN_DATA);

    // ======================================================
    // Ticks: seconds from the clock, minutes from seconds
    wire logic sec_tick = sec_cnt == CYC_PER_SEC - 1;
    wire logic min_tick = sec_tick && min_cnt == 6'(`WDGP_SEC_PER_MIN - 1);
    wire logic unit_min = address_decode_enable[`WDGP_DEC_UNIT_MIN];
    wire logic unit_tick = unit_min ? min_tick : sec_tick;

    // Prescalers run freely, so the first unit may be short
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sec_cnt <= 32'h0;
            min_cnt <= 6'h0;
        end
        else
        begin
            sec_cnt <= sec_tick ? 32'h0 : sec_cnt + 32'h1;
            if (sec_tick)
                min_cnt <= min_tick ? 6'h0 : min_cnt + 6'h1;
        end
    end

    // ======================================================
    // Restart events reduced to one-cycle pulses
    wire logic game_hit = io_strobe && io_address == `WDGP_GAME_ADDR;
    wire logic kbd_pulse = keyboard_irq && !kbd_q;
    wire logic mouse_pulse = mouse_irq && !mouse_q;
    wire logic game_pulse = game_hit && !game_q;
    wire logic restart = (kbd_pulse && watchdog_config[`WDGP_CFG_KBD_EN])
        || (mouse_pulse && watchdog_config[`WDGP_CFG_MOUSE_EN])
        || (game_pulse && watchdog_config[`WDGP_CFG_JOY_EN]);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            kbd_q <= 1'b0;
            mouse_q <= 1'b0;
            game_q <= 1'b0;
        end
        else
        begin
            kbd_q <= keyboard_irq;
            mouse_q <= mouse_irq;
            game_q <= game_hit;
        end
    end

    // ======================================================
    // Counter and status
    wire logic enabled = watchdog_reload_value != 8'h00;
    wire logic force_to = wr_ctrl && wbyte[`WDGP_CTRL_FORCE];
    wire logic expire = enabled && count == 8'h01 && unit_tick;
    wire logic [7:0] next_count =
        force_to ? 8'h00 :
        wr_reload ? wbyte :
        restart ? watchdog_reload_value :
        (enabled && count != 8'h00 && unit_tick) ? count - 8'h01 : count;
    // Hardware set beats any clear in the same cycle
    wire logic next_status =
        (expire || force_to) ? 1'b1 :
        restart ? 1'b0 :
        wr_ctrl ? wbyte[`WDGP_CTRL_STATUS] :
        watchdog_control.status;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count <= 8'h00;
            watchdog_control <= '0;
        end
        else
        begin
            count <= next_count;
            watchdog_control.status <= next_status;
            watchdog_control.force_out <= 1'b0;
            if (wr_ctrl)
            begin
                watchdog_control.led_toggle <= wbyte[1];
                watchdog_control.spare <= wbyte[7:3];
            end
        end
    end

    // ======================================================
    // Pin functions
    wire logic ir_sel = ir_options[`WDGP_IR_SELECT];
    logic [`WDGP_NPINS-1:0] alt_sig, alt_out_type, drive, eff, next_data;
    logic alt_in_12, alt_in_10, alt_in_11;

    // Alternate signal per slot; pin 12 flips type with IR select
    always_comb
    begin
        alt_sig = '0;
        alt_out_type = '1;
        alt_sig[`WDGP_PIN_12] = watchdog_control.status;
        alt_out_type[`WDGP_PIN_12] = !ir_sel;
        alt_out_type[`WDGP_PIN_10] = 1'b0;
        alt_out_type[`WDGP_PIN_11] = 1'b0;
        alt_sig[`WDGP_PIN_13] = ir_sel ? infrared_transmit : 1'b1;
        alt_sig[`WDGP_PIN_46] = watchdog_control.status;
        alt_sig[`WDGP_PIN_61] = watchdog_control.status;
    end

    // Drive, effective level and data write per pin
    always_comb
    begin
        for (int i = 0; i < `WDGP_NPINS; i++)
        begin
            drive[i] = (pin_config[i].alt && alt_out_type[i] ? alt_sig[i] : pin_data[i])
                ^ pin_config[i].invert;
            eff[i] = pin_config[i].is_input ? pin_sync[i] ^ pin_config[i].invert : drive[i];
            next_data[i] = (wr_data && !pin_config[i].is_input) ? wbyte[i] : pin_data[i];
        end
    end

    wire logic [`WDGP_NPINS-1:0] ie_vec = {
        pin_config[5].int_en, pin_config[4].int_en, pin_config[3].int_en,
        pin_config[2].int_en, pin_config[1].int_en, pin_config[0].int_en};
    wire logic [`WDGP_NPINS-1:0] dir_vec = {
        pin_config[5].is_input, pin_config[4].is_input, pin_config[3].is_input,
        pin_config[2].is_input, pin_config[1].is_input, pin_config[0].is_input};

    // Input-type alternates only feed when the pin is an input
    always_comb
    begin
        alt_in_12 = pin_config[`WDGP_PIN_12].alt && ir_sel && dir_vec[`WDGP_PIN_12]
            && eff[`WDGP_PIN_12];
        alt_in_10 = pin_config[`WDGP_PIN_10].alt && dir_vec[`WDGP_PIN_10] && eff[`WDGP_PIN_10];
        alt_in_11 = pin_config[`WDGP_PIN_11].alt && dir_vec[`WDGP_PIN_11] && eff[`WDGP_PIN_11];
    end

    // ======================================================
    // Read mux, sampled in the address phase
    logic [7:0] rd_byte;
    always_comb
    begin
        rd_byte = 8'h00;
        unique case (aoff)
            `WDGP_OFF_RELOAD: rd_byte = watchdog_reload_value;
            `WDGP_OFF_CONFIG: rd_byte = watchdog_config;
            `WDGP_OFF_CONTROL: rd_byte = watchdog_control;
            `WDGP_OFF_DEC_EN: rd_byte = address_decode_enable;
            `WDGP_OFF_IR_OPT: rd_byte = ir_options;
            `WDGP_OFF_PIN_DATA: rd_byte = {2'b00, (dir_vec & eff) | (~dir_vec & pin_data)};
            default:
            begin
                for (int i = 0; i < `WDGP_NPINS; i++)
                    if (aoff == `WDGP_OFF_PIN_CFG + 8'(4 * i))
                        rd_byte = pin_config[i];
            end
        endcase
    end

    // ======================================================
    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            req <= '0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            req <= '{valid: take, write: hwrite, offset: aoff};
            if (take && !hwrite)
                hrdata <= {24'h0, rd_byte};
        end
    end

    // Software-written registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            watchdog_reload_value <= `WDGP_RELOAD_RST;
            watchdog_config <= 8'h00;
            address_decode_enable <= 8'h00;
            ir_options <= 8'h00;
            pin_data <= '0;
            for (int i = 0; i < `WDGP_NPINS; i++)
                pin_config[i] <= `WDGP_PIN_CFG_RST;
        end
        else
        begin
            pin_data <= next_data;
            if (wr_reload)
                watchdog_reload_value <= wbyte;
            if (wr_config)
                watchdog_config <= wbyte;
            if (wr_dec)
                address_decode_enable <= wbyte;
            if (wr_ir)
                ir_options <= wbyte;
            for (int i = 0; i < `WDGP_NPINS; i++)
                if (hit(req, `WDGP_OFF_PIN_CFG + 8'(4 * i)))
                    pin_config[i] <= wbyte;
        end
    end

    // ======================================================
    // Pin synchroniser and registered outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
            general_purpose_pin_out <= '0;
            general_purpose_pin_oe <= '0;
            combined_pin_interrupt <= 1'b0;
            watchdog_irq <= 1'b0;
            watchdog_irq_channel <= 4'h0;
            gpio_pin_10_irq <= 1'b0;
            gpio_pin_11_irq <= 1'b0;
            infrared_receive <= 1'b0;
            watchdog_timeout <= 1'b0;
        end
        else
        begin
            pin_meta <= general_purpose_pin_in;
            pin_sync <= pin_meta;
            general_purpose_pin_out <= drive;
            general_purpose_pin_oe <= ~dir_vec;
            combined_pin_interrupt <= |(ie_vec & eff);
            watchdog_irq <= watchdog_config[7:4] != 4'h0 && watchdog_control.status;
            watchdog_irq_channel <= watchdog_config[7:4];
            gpio_pin_10_irq <= alt_in_10;
            gpio_pin_11_irq <= alt_in_11;
            infrared_receive <= alt_in_12;
            watchdog_timeout <= watchdog_control.status;
        end
    end

    // ======================================================
    // Checks
    chk_zero_disables: assert property (@(posedge hclk) disable iff (!hresetn)
        !enabled && !force_to && !wr_reload |=> count == $past(count))
        else $error("count moved while disabled");
    chk_reload_load: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_reload && !force_to |=> count == $past(wbyte))
        else $error("reload write did not load counter");
    // A restart or reload in the expiry cycle reloads the count while the flag still sets
    chk_expire_sets: assert property (@(posedge hclk) disable iff (!hresetn)
        expire && !restart && !wr_reload |=> watchdog_control.status && count == 8'h00)
        else $error("expiry did not set status");
    chk_status_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl && !expire && !force_to && !restart |=> watchdog_control.status == $past(wbyte[0]))
        else $error("status write lost");
    chk_restart_reload: assert property (@(posedge hclk) disable iff (!hresetn)
        restart && !force_to && !wr_reload && !expire |=> count == $past(watchdog_reload_value)
        && !watchdog_control.status)
        else $error("restart did not reload");
    chk_irq_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        watchdog_config[7:4] == 4'h0 |=> !watchdog_irq)
        else $error("unmapped interrupt asserted");
    chk_force_self: assert property (@(posedge hclk) disable iff (!hresetn)
        force_to |=> watchdog_control.status && count == 8'h00 && !watchdog_control.force_out)
        else $error("force timeout misbehaved");
    chk_input_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_data && pin_config[0].is_input |=> pin_data[0] == $past(pin_data[0]))
        else $error("input pin data changed by write");
    chk_pulse_once: assert property (@(posedge hclk) disable iff (!hresetn)
        kbd_pulse |=> !kbd_pulse)
        else $error("keyboard pulse longer than a cycle");
    cov_expire: cover property (@(posedge hclk) disable iff (!hresetn) expire);
    cov_restart: cover property (@(posedge hclk) disable iff (!hresetn) restart);
    cov_force: cover property (@(posedge hclk) disable iff (!hresetn) force_to);

endmodule : wdgp_top
